//--- include/cfs_pkg.sv
// constants and types shared by the flag, stack and bank state unit
package cfs_pkg;
  // register offsets in logical register space
  localparam logic [7:0] ADDR_FLAG_SAVE   = 8'hCF;
  localparam logic [7:0] ADDR_STK_INDEX   = 8'hF6;
  localparam logic [7:0] ADDR_STK_PORT    = 8'hF7;
  localparam logic [7:0] ADDR_BANK_SELECT = 8'hFC;
  localparam logic [7:0] ADDR_FLAGS       = 8'hFF;
  // flag bit positions
  localparam int FLAG_CARRY = 7;
  localparam int FLAG_ZERO  = 6;
  localparam int FLAG_SIGN  = 5;
  localparam int FLAG_TRAP  = 4;
  localparam int FLAG_OFLO  = 3;
  localparam int FLAG_FULL  = 2;
  localparam int FLAG_GIE   = 0;
  // save register keeps carry, zero, sign, trap and gie only
  localparam logic [7:0] SAVE_MASK = 8'hF1;
  // index map of the stack window
  localparam logic [5:0] IDX_LAST_BYTE = 6'h1F;
  localparam logic [5:0] IDX_PUSH_PTR  = 6'h3E;
  localparam logic [5:0] IDX_POP_PTR   = 6'h3F;
  // banking
  localparam logic [7:0] BANKED_LO = 8'h80;
  localparam logic [7:0] BANKED_HI = 8'hBF;
  // reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] SAVE_RST  = 8'h00;
  localparam logic [5:0] INDEX_RST = 6'h00;
  localparam logic [4:0] BANK_RST  = 5'h00;
  localparam logic [3:0] PTR_RST   = 4'h0;
  localparam int STACK_DEPTH = 16;

  typedef struct packed {
    logic [7:0]  flags;
    logic [7:0]  save;
    logic [5:0]  index;
    logic [4:0]  bank;
    logic [3:0]  push_ptr;
    logic [3:0]  pop_ptr;
    logic [15:0][15:0] stack;
    logic [7:0]  rdata;
    logic [10:0] phys_addr;
    logic        phys_banked;
    logic [15:0] ret_pc;
    logic        irq_take;
  } cfs_state_type;
endpackage

//--- rtl/cfs_core_state.sv
// condition flags, flag save copy, return stack and register banking
//
// What this block does
// - carry bit 7, zero bit 6 on zero result
// - sign bit 5 follows result msb
// - sticky overflow bit 3, reset clears only
// - full bit tracks pointers, clears itself
// - bit 0 gates interrupt acceptance
// - interrupt entry copies flags into save
// - save register readable and writable, bits 3..1 read zero
// - return reloads flags, stack bits untouched
// - direct gie writes also update save gie
// - sixteen entry 16-bit return stack
// - pointers wrap modulo sixteen silently
// - separate 4-bit push and pop pointers
// - index at F6 selects byte at F7
// - index 00-1F bytewise, low byte even
// - index 3E push, 3F pop pointer
// - 00-7F and C0-FF map directly
// - banked address is bank and low six
`timescale 1ns/1ps
`default_nettype none
module cfs_core_state (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // register access from instruction execution
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // alu result update
  input  wire logic        alu_upd,
  input  wire logic [7:0]  alu_result,
  input  wire logic        alu_carry,
  // call and return
  input  wire logic        call_push,
  input  wire logic        ret_pop,
  input  wire logic [15:0] call_pc,
  output logic      [15:0] ret_pc,
  // interrupt sequencing
  input  wire logic        irq_req,
  input  wire logic        irq_enter,
  input  wire logic        irq_return,
  output logic             irq_take,
  // register ram address mapping
  input  wire logic [7:0]  map_addr,
  output logic      [10:0] phys_addr,
  output logic             phys_banked,
  // flags for the core
  output logic      [7:0]  flags_out
);
  cfs_pkg::cfs_state_type s_q, s_d;

  logic [3:0] next_push;
  logic       full_now;
  logic       oflo_now;
  logic [3:0] ent;

  always_comb begin
    s_d = s_q;
    next_push = s_q.push_ptr;
    ent = s_q.index[4:1];
    // ***************************************************
    // stack pointers and contents
    // ***************************************************
    // push on call or interrupt
    if (call_push || irq_enter) begin
      s_d.stack[s_q.push_ptr] = call_pc;
      s_d.pop_ptr = s_q.push_ptr;
      next_push = s_q.push_ptr + 4'h1;
      s_d.push_ptr = next_push;
    end else if (ret_pop) begin
      s_d.push_ptr = s_q.pop_ptr;
      s_d.pop_ptr = s_q.pop_ptr - 4'h1;
    end
    // ***************************************************
    // register writes
    // ***************************************************
    if (reg_wr) begin
      case (reg_addr)
        cfs_pkg::ADDR_FLAG_SAVE:   s_d.save = reg_wdata & cfs_pkg::SAVE_MASK;
        cfs_pkg::ADDR_STK_INDEX:   s_d.index = reg_wdata[5:0];
        cfs_pkg::ADDR_STK_PORT: begin
          // even low byte, odd high byte
          if (s_q.index <= cfs_pkg::IDX_LAST_BYTE) begin
            if (s_q.index[0])
              s_d.stack[ent][15:8] = reg_wdata;
            else
              s_d.stack[ent][7:0] = reg_wdata;
          end else if (s_q.index == cfs_pkg::IDX_PUSH_PTR) begin
            s_d.push_ptr = reg_wdata[3:0];
          end else if (s_q.index == cfs_pkg::IDX_POP_PTR) begin
            s_d.pop_ptr = reg_wdata[3:0];
          end
        end
        cfs_pkg::ADDR_BANK_SELECT: s_d.bank = reg_wdata[4:0];
        cfs_pkg::ADDR_FLAGS: begin
          // stack indicators are read-only
          s_d.flags[7:4] = reg_wdata[7:4];
          s_d.flags[1] = 1'b0;
          s_d.flags[cfs_pkg::FLAG_GIE] = reg_wdata[cfs_pkg::FLAG_GIE];
          // gie write shadows into save, kept as built
          s_d.save[cfs_pkg::FLAG_GIE] = reg_wdata[cfs_pkg::FLAG_GIE];
        end
        default: ;
      endcase
    end
    // ***************************************************
    // flag updates from alu and interrupt flow
    // ***************************************************
    if (alu_upd) begin
      s_d.flags[cfs_pkg::FLAG_CARRY] = alu_carry;
      s_d.flags[cfs_pkg::FLAG_ZERO] = (alu_result == 8'h00);
      s_d.flags[cfs_pkg::FLAG_SIGN] = alu_result[7];
    end
    if (irq_enter) begin
      s_d.save = s_q.flags & cfs_pkg::SAVE_MASK;
    end else if (irq_return) begin
      s_d.flags = (s_q.save & cfs_pkg::SAVE_MASK)
                | (s_q.flags & ~cfs_pkg::SAVE_MASK);
    end
    // full while push and pop pointers are equal
    full_now = (s_d.push_ptr == s_d.pop_ptr + 4'h1) ? 1'b0
             : (s_d.push_ptr == s_d.pop_ptr);
    s_d.flags[cfs_pkg::FLAG_FULL] = full_now;
    // overflow is sticky: a push while already full
    oflo_now = (call_push || irq_enter) && s_q.flags[cfs_pkg::FLAG_FULL];
    s_d.flags[cfs_pkg::FLAG_OFLO] = s_q.flags[cfs_pkg::FLAG_OFLO] | oflo_now;
    // ***************************************************
    // read data, mapping and interrupt gate
    // ***************************************************
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        cfs_pkg::ADDR_FLAG_SAVE:   s_d.rdata = s_q.save & cfs_pkg::SAVE_MASK;
        cfs_pkg::ADDR_STK_INDEX:   s_d.rdata = {2'b00, s_q.index};
        cfs_pkg::ADDR_STK_PORT: begin
          if (s_q.index <= cfs_pkg::IDX_LAST_BYTE)
            s_d.rdata = s_q.index[0] ? s_q.stack[ent][15:8] : s_q.stack[ent][7:0];
          else if (s_q.index == cfs_pkg::IDX_PUSH_PTR)
            s_d.rdata = {4'h0, s_q.push_ptr};
          else if (s_q.index == cfs_pkg::IDX_POP_PTR)
            s_d.rdata = {4'h0, s_q.pop_ptr};
          else
            s_d.rdata = 8'h00;
        end
        cfs_pkg::ADDR_BANK_SELECT: s_d.rdata = {3'b000, s_q.bank};
        cfs_pkg::ADDR_FLAGS:       s_d.rdata = s_q.flags;
        default:                   s_d.rdata = 8'h00;
      endcase
    end
    if (map_addr >= cfs_pkg::BANKED_LO && map_addr <= cfs_pkg::BANKED_HI) begin
      s_d.phys_addr = {s_q.bank, map_addr[5:0]};
      s_d.phys_banked = 1'b1;
    end else begin
      s_d.phys_addr = {3'b000, map_addr};
      s_d.phys_banked = 1'b0;
    end
    // top of stack for return, registered a cycle ahead of use
    s_d.ret_pc = s_d.stack[s_d.pop_ptr];
    // requests accepted only while gie set
    s_d.irq_take = irq_req && s_q.flags[cfs_pkg::FLAG_GIE] && !irq_enter;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.flags <= cfs_pkg::FLAGS_RST;
      s_q.save <= cfs_pkg::SAVE_RST;
      s_q.index <= cfs_pkg::INDEX_RST;
      s_q.bank <= cfs_pkg::BANK_RST;
      s_q.push_ptr <= cfs_pkg::PTR_RST;
      s_q.pop_ptr <= cfs_pkg::PTR_RST - 4'h1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata   = s_q.rdata;
  assign ret_pc      = s_q.ret_pc;
  assign irq_take    = s_q.irq_take;
  assign phys_addr   = s_q.phys_addr;
  assign phys_banked = s_q.phys_banked;
  assign flags_out   = s_q.flags;
endmodule
`default_nettype wire

//--- sim/cfs_core_state_asserts.sv
// port checker for the flag, stack and bank unit
`timescale 1ns/1ps
`default_nettype none
module cfs_core_state_asserts (
  input wire logic        clk_sys, resetn, reg_rd, alu_upd, alu_carry, call_push,
  input wire logic        irq_req, irq_enter, irq_return, irq_take, phys_banked,
  input wire logic [7:0]  reg_addr, reg_rdata, alu_result, map_addr, flags_out,
  input wire logic [15:0] call_pc, ret_pc,
  input wire logic [10:0] phys_addr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // return restore may race the alu, so those cycles are left out
  sequence s_alu; alu_upd && !irq_return; endsequence
  sequence s_bank; map_addr[7:6] == 2'b10; endsequence
  property p_zero; s_alu |=> flags_out[7:6] == {$past(alu_carry), $past(alu_result) == 8'h00};
  endproperty
  a_zero: assert property (p_zero) else $error("bad carry or zero");
  property p_sign; s_alu |=> flags_out[5] == $past(alu_result[7]); endproperty
  a_sign: assert property (p_sign) else $error("bad sign");
  property p_oflo; flags_out[3] |=> flags_out[3]; endproperty
  a_oflo: assert property (p_oflo) else $error("overflow cleared");
  property p_bit1; flags_out[1] == 1'b0; endproperty
  a_bit1: assert property (p_bit1) else $error("bit 1 set");
  property p_save; reg_rd && reg_addr == 8'hCF |=> reg_rdata[3:1] == 3'h0; endproperty
  a_save: assert property (p_save) else $error("save bits 3..1 set");
  property p_gate; !flags_out[0] |=> !irq_take; endproperty
  a_gate: assert property (p_gate) else $error("take while disabled");
  property p_take; irq_req && flags_out[0] && !irq_enter |=> irq_take; endproperty
  a_take: assert property (p_take) else $error("request not taken");
  property p_push; call_push || irq_enter |=> ret_pc == $past(call_pc); endproperty
  a_push: assert property (p_push) else $error("pc not on top");
  property p_bank; s_bank |=> phys_banked && phys_addr[5:0] == $past(map_addr[5:0]); endproperty
  a_bank: assert property (p_bank) else $error("bad banked address");
endmodule
bind cfs_core_state cfs_core_state_asserts u_chk (.clk_sys(clk_sys), .resetn(resetn),
  .reg_rd(reg_rd), .alu_upd(alu_upd), .alu_carry(alu_carry), .call_push(call_push),
  .irq_req(irq_req), .irq_enter(irq_enter), .irq_return(irq_return), .irq_take(irq_take),
  .phys_banked(phys_banked), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .alu_result(alu_result), .map_addr(map_addr), .flags_out(flags_out), .call_pc(call_pc),
  .ret_pc(ret_pc), .phys_addr(phys_addr));
`default_nettype wire

//--- sim/cfs_seq_model.sv
// core interrupt sequencer model, answers an accepted request late or prompt
`timescale 1ns/1ps
`default_nettype none
module cfs_seq_model (
  input wire logic clk_sys,
  input wire logic irq_take,
  output logic     irq_enter
);
  int lag;
  initial irq_enter = 1'b0;
  always @(negedge clk_sys) begin
    irq_enter <= 1'b0;
    if (irq_take && !irq_enter) begin
      lag = $urandom_range(3);
      repeat (lag) @(negedge clk_sys);
      irq_enter <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench of the flag, stack and bank unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys, resetn, reg_wr, reg_rd, alu_upd, alu_carry, call_push, ret_pop, ofl;
  logic irq_req, irq_enter, irq_return, irq_take, phys_banked;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, alu_result, map_addr, flags_out, fl, sv;
  logic [15:0] call_pc, ret_pc, stk [16];
  logic [10:0] phys_addr;
  logic [5:0] idx;
  logic [4:0] bk;
  logic [3:0] pu, po;
  int miscompares, cmp_count, cyc, n;
  cfs_core_state dut (.clk_sys(clk_sys), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .alu_upd(alu_upd),
    .alu_result(alu_result), .alu_carry(alu_carry), .call_push(call_push), .ret_pop(ret_pop),
    .call_pc(call_pc), .ret_pc(ret_pc), .irq_req(irq_req), .irq_enter(irq_enter),
    .irq_return(irq_return), .irq_take(irq_take), .map_addr(map_addr), .phys_addr(phys_addr),
    .phys_banked(phys_banked), .flags_out(flags_out));
  cfs_seq_model u_seq (.clk_sys(clk_sys), .irq_take(irq_take), .irq_enter(irq_enter));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic final_report();
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic chk(input string s, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic step();
    @(negedge clk_sys);
    {reg_wr, reg_rd, alu_upd, call_push, ret_pop, irq_return} = 6'h00;
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(negedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
    step();
    case (a)
      8'hFF: {fl, sv[0]} = {v & 8'hF1, v[0]};
      8'hCF: sv = v & 8'hF1;
      8'hF6: idx = v[5:0];
      8'hFC: bk = v[4:0];
      8'hF7: if (idx == 6'h3E) pu = v[3:0];
        else if (idx == 6'h3F) po = v[3:0];
        else if (idx < 6'h20) stk[idx[4:1]][idx[0] * 8 +: 8] = v;
      default: ;
    endcase
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    e = a == 8'hFF ? {fl[7:4], ofl, pu == po, 1'b0, fl[0]} : a == 8'hCF ? sv :
      a == 8'hF6 ? {2'h0, idx} : a == 8'hFC ? {3'h0, bk} : 8'h00;
    if (a == 8'hF7)
      e = idx == 6'h3E ? {4'h0, pu} : idx == 6'h3F ? {4'h0, po} :
        idx < 6'h20 ? stk[idx[4:1]][idx[0] * 8 +: 8] : 8'h00;
    @(negedge clk_sys);
    {reg_rd, reg_addr} = {1'b1, a};
    step();
    chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic mpush(input logic [15:0] pc);
    ofl |= pu == po;
    stk[pu] = pc;
    po = pu;
    pu++;
    chk("ret_pc", stk[po], ret_pc);
  endtask
  task automatic push(input logic [15:0] pc);
    @(negedge clk_sys);
    {call_push, call_pc} = {1'b1, pc};
    step();
    mpush(pc);
  endtask
  task automatic map(input logic [7:0] a);
    @(negedge clk_sys);
    map_addr = a;
    @(negedge clk_sys);
    chk("phys_addr", a[7:6] == 2'b10 ? {bk, a[5:0]} : {3'h0, a}, phys_addr);
    chk("phys_banked", a[7:6] == 2'b10, phys_banked);
  endtask
  initial begin
    {resetn, reg_wr, reg_rd, alu_upd, alu_carry, call_push, ret_pop, irq_req} = 8'h00;
    {irq_return, reg_addr, reg_wdata, alu_result, map_addr, call_pc} = 49'h0;
    {fl, sv, idx, bk, pu, po, ofl} = {31'h0, 4'hF, 1'b0};
    void'($urandom(32'h98E2));
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    rd(8'hFF);
    rd(8'hCF);
    rd(8'h10);
    wr(8'hCF, 8'($urandom) & 8'hEF);
    rd(8'hCF);
    wr(8'hFF, 8'($urandom) & 8'hEF | 8'h0E);
    rd(8'hFF);
    rd(8'hCF);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      {alu_upd, alu_result, alu_carry} = {1'b1, i[0] ? 8'($urandom) : 8'h00, 1'($urandom)};
      step();
      fl[7:5] = {alu_carry, alu_result == 8'h00, alu_result[7]};
      rd(8'hFF);
    end
    for (int i = 0; i < 17; i++) push(16'($urandom));
    for (int i = 0; i < 34; i += 11) begin
      wr(8'hF6, 8'(i));
      rd(8'hF7);
    end
    repeat (3) begin
      @(negedge clk_sys);
      ret_pop = 1'b1;
      step();
      pu = po;
      po--;
      chk("ret_pc", stk[po], ret_pc);
    end
    for (int i = 62; i < 64; i++) begin
      wr(8'hF6, 8'(i));
      rd(8'hF7);
      wr(8'hF7, 8'h05);
    end
    rd(8'hFF);
    push(16'($urandom));
    rd(8'hFF);
    for (int b = 0; b < 12; b++) begin
      wr(8'hFC, 8'(b));
      rd(8'hFC);
      map({2'b10, 6'($urandom)});
      map(8'($urandom) & 8'h7F | {2'($urandom), 6'h0} & 8'hC0);
    end
    wr(8'hFF, 8'h00);
    irq_req = 1'b1;
    step();
    chk("irq_take", 0, irq_take);
    irq_req = 1'b0;
    wr(8'hFF, 8'hA1);
    irq_req = 1'b1;
    for (n = 0; n < 20 && !irq_enter; n++) @(posedge clk_sys);
    @(negedge clk_sys);
    irq_req = 1'b0;
    sv = fl;
    mpush(call_pc);
    chk("irq_enter", 1, n < 20);
    rd(8'hCF);
    wr(8'hFF, 8'hC0);
    rd(8'hCF);
    wr(8'hCF, 8'hA1);
    @(negedge clk_sys);
    irq_return = 1'b1;
    step();
    fl = sv;
    rd(8'hFF);
    final_report();
  end
endmodule
`default_nettype wire
